/* core/iwd_pkg.sv */
// package: field layout, opcode map, cycle counts for the instruction word decoder
package iwd_pkg;

  // ----------------------------------------------------------------
  // word and field geometry
  // ----------------------------------------------------------------
  localparam int W_WORD = 24;
  localparam int W_OPC = 8;
  localparam int W_REG = 4;
  localparam int W_MODE = 2;
  localparam int W_FADDR = 13;
  localparam int W_LIT = 16;
  localparam int W_PADDR = 23;
  localparam int W_TMODE = 2;
  localparam int W_LIT5 = 5;
  localparam int W_LITW = 12;
  localparam int W_PHI = 7;
  localparam int OPC_LSB = 16;
  localparam int F_BASE_LSB = 12;
  localparam int F_DST_LSB = 8;
  localparam int F_DMODE_LSB = 6;
  localparam int F_SRC_LSB = 2;
  localparam int F_SMODE_LSB = 0;
  localparam int F_FADDR_LSB = 0;
  localparam int F_FDEST_BIT = 13;
  localparam int F_IND_BIT = 11;
  localparam int F_FBIT_LSB = 13;
  localparam int F_FBIT_HI = 16;
  localparam int F_TMODE_LSB = 14;
  localparam int F_LIT5_LSB = 0;
  localparam int F_LITW_LSB = 4;
  localparam int F_LITREG_LSB = 0;
  localparam int F_PHI_LSB = 0;

  // file register space tops out at 13 bits, working registers at 16
  localparam logic [W_FADDR-1:0] FADDR_MAX = 13'h1fff;
  localparam logic [W_REG-1:0] WORKING_REG_ZERO_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // opcode map
  // ----------------------------------------------------------------
  localparam logic [W_OPC-1:0] OP_NOP = 8'h00;
  localparam logic [W_OPC-1:0] OP_LIT_MOV_W = 8'h90;
  localparam logic [W_OPC-1:0] OP_LIT_MOV_F = 8'h91;
  localparam logic [W_OPC-1:0] OP_BRANCH = 8'ha0;
  localparam logic [W_OPC-1:0] OP_CALL_IND = 8'hb0;
  localparam logic [W_OPC-1:0] OP_GOTO_IND = 8'hb1;
  localparam logic [W_OPC-1:0] OP_CALL_ABS = 8'hb2;
  localparam logic [W_OPC-1:0] OP_GOTO_ABS = 8'hb3;
  localparam logic [W_OPC-1:0] OP_RETURN = 8'hb8;
  localparam logic [W_OPC-1:0] OP_RETURN_FROM_INTERRUPT = 8'hb9;
  localparam logic [W_OPC-1:0] OP_MOV_DW = 8'hc0;

  // ----------------------------------------------------------------
  // execution cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [1:0] CYC_ZERO = 2'h0;

  typedef enum logic [4:0] {
    CAT_NOP, CAT_WORKING_REG_ZERO, CAT_FILE, CAT_BIT_W, CAT_BIT_F, CAT_LIT_ARITH,
    CAT_LIT_MOV_W, CAT_LIT_MOV_F, CAT_BRANCH, CAT_COND_BRANCH, CAT_SKIP,
    CAT_CALL_IND, CAT_GOTO_IND, CAT_CALL_ABS, CAT_GOTO_ABS, CAT_TABLE,
    CAT_RETURN, CAT_RETURN_FROM_INTERRUPT, CAT_MOV_DW
  } iwd_cat_t;

  // opcode to category; unused codes run as no-operation
  function automatic iwd_cat_t iwd_classify(input logic [W_OPC-1:0] op);
    iwd_cat_t c;
    c = CAT_NOP;
    if (op >= 8'h10 && op <= 8'h3f) c = CAT_WORKING_REG_ZERO;
    else if (op >= 8'h40 && op <= 8'h5f) c = CAT_FILE;
    else if (op >= 8'h60 && op <= 8'h6f) c = CAT_BIT_W;
    else if (op >= 8'h70 && op <= 8'h7f) c = CAT_BIT_F;
    else if (op >= 8'h80 && op <= 8'h8f) c = CAT_LIT_ARITH;
    else if (op == OP_LIT_MOV_W) c = CAT_LIT_MOV_W;
    else if (op == OP_LIT_MOV_F) c = CAT_LIT_MOV_F;
    else if (op == OP_BRANCH) c = CAT_BRANCH;
    else if (op >= 8'ha1 && op <= 8'ha7) c = CAT_COND_BRANCH;
    else if (op >= 8'ha8 && op <= 8'hab) c = CAT_SKIP;
    else if (op == OP_CALL_IND) c = CAT_CALL_IND;
    else if (op == OP_GOTO_IND) c = CAT_GOTO_IND;
    else if (op == OP_CALL_ABS) c = CAT_CALL_ABS;
    else if (op == OP_GOTO_ABS) c = CAT_GOTO_ABS;
    else if (op >= 8'hb4 && op <= 8'hb7) c = CAT_TABLE;
    else if (op == OP_RETURN) c = CAT_RETURN;
    else if (op == OP_RETURN_FROM_INTERRUPT) c = CAT_RETURN_FROM_INTERRUPT;
    else if (op == OP_MOV_DW) c = CAT_MOV_DW;
    return c;
  endfunction

  // the only three opcodes that span two program words
  function automatic logic iwd_two_word(input logic [W_OPC-1:0] op);
    return (op == OP_LIT_MOV_F) || (op == OP_CALL_ABS) || (op == OP_GOTO_ABS);
  endfunction

endpackage

/* core/iwd_fields.sv */
// operand field extraction for one decoded instruction
`timescale 1ns/1ns
module iwd_fields
  import iwd_pkg::*;
(
  // instruction in
  input wire iwd_cat_t cat_i,
  input wire logic [W_WORD-1:0] word1_i,
  input wire logic [W_WORD-1:0] word2_i,
  // operands out
  output logic [W_REG-1:0] base_source_register_o,
  output logic [W_REG-1:0] second_source_register_o,
  output logic [W_MODE-1:0] src_mode_o,
  output logic [W_REG-1:0] destination_register_o,
  output logic [W_MODE-1:0] dst_mode_o,
  output logic [W_FADDR-1:0] file_addr_o,
  output logic file_to_working_reg_zero_o,
  output logic [W_REG-1:0] bit_pos_o,
  output logic bit_indirect_o,
  output logic [W_LIT-1:0] literal_o,
  output logic [W_PADDR-1:0] prog_addr_o,
  output logic [W_TMODE-1:0] table_mode_o,
  output logic dest_separate_o
);

  // defaults first so unused fields read as zero for every category
  always_comb begin
    base_source_register_o = '0;
    second_source_register_o = '0;
    src_mode_o = '0;
    destination_register_o = '0;
    dst_mode_o = '0;
    file_addr_o = '0;
    file_to_working_reg_zero_o = 1'b0;
    bit_pos_o = '0;
    bit_indirect_o = 1'b0;
    literal_o = '0;
    prog_addr_o = '0;
    table_mode_o = '0;
    dest_separate_o = 1'b0;
    unique case (cat_i)
      CAT_WORKING_REG_ZERO, CAT_MOV_DW: begin
        base_source_register_o = word1_i[F_BASE_LSB +: W_REG];
        destination_register_o = word1_i[F_DST_LSB +: W_REG];
        dst_mode_o = word1_i[F_DMODE_LSB +: W_MODE];
        second_source_register_o = word1_i[F_SRC_LSB +: W_REG];
        src_mode_o = word1_i[F_SMODE_LSB +: W_MODE];
        dest_separate_o = 1'b1;
      end
      CAT_FILE: begin
        file_addr_o = word1_i[F_FADDR_LSB +: W_FADDR];
        file_to_working_reg_zero_o = word1_i[F_FDEST_BIT];
        destination_register_o = WORKING_REG_ZERO_ZERO;
      end
      // bit from literal or from base register
      CAT_BIT_W: begin
        bit_indirect_o = word1_i[F_IND_BIT];
        base_source_register_o = word1_i[F_BASE_LSB +: W_REG];
        bit_pos_o = word1_i[F_IND_BIT] ? '0 : word1_i[F_BASE_LSB +: W_REG];
        second_source_register_o = word1_i[F_SRC_LSB +: W_REG];
        src_mode_o = word1_i[F_SMODE_LSB +: W_MODE];
      end
      // file target; top bit of position rides in the opcode
      CAT_BIT_F: begin
        bit_pos_o = {word1_i[F_FBIT_HI], word1_i[F_FBIT_LSB +: W_REG-1]};
        file_addr_o = {3'h0, word1_i[F_FADDR_LSB +: W_FADDR-3]};
      end
      // separate destination only when it differs
      CAT_LIT_ARITH: begin
        base_source_register_o = word1_i[F_BASE_LSB +: W_REG];
        literal_o = {11'h000, word1_i[F_LIT5_LSB +: W_LIT5]};
        dest_separate_o = word1_i[F_DST_LSB +: W_REG] != word1_i[F_BASE_LSB +: W_REG];
        destination_register_o = word1_i[F_DST_LSB +: W_REG];
        dst_mode_o = dest_separate_o ? word1_i[F_DMODE_LSB +: W_MODE] : '0;
        if (!dest_separate_o) destination_register_o = word1_i[F_BASE_LSB +: W_REG];
      end
      CAT_LIT_MOV_W: begin
        literal_o = {4'h0, word1_i[F_LITW_LSB +: W_LITW]};
        base_source_register_o = word1_i[F_LITREG_LSB +: W_REG];
        destination_register_o = word1_i[F_LITREG_LSB +: W_REG];
      end
      // literal into file register, literal in second word
      CAT_LIT_MOV_F: begin
        file_addr_o = word1_i[F_FADDR_LSB +: W_FADDR];
        literal_o = word2_i[0 +: W_LIT];
      end
      CAT_BRANCH, CAT_COND_BRANCH: begin
        prog_addr_o = {7'h00, word1_i[0 +: W_LIT]};
      end
      CAT_CALL_ABS, CAT_GOTO_ABS: begin
        prog_addr_o = {word2_i[F_PHI_LSB +: W_PHI], word1_i[0 +: W_LIT]};
      end
      CAT_CALL_IND, CAT_GOTO_IND, CAT_SKIP: begin
        second_source_register_o = word1_i[F_SRC_LSB +: W_REG];
        file_addr_o = word1_i[F_FADDR_LSB +: W_FADDR];
      end
      CAT_TABLE: begin
        table_mode_o = word1_i[F_TMODE_LSB +: W_TMODE];
        destination_register_o = word1_i[F_DST_LSB +: W_REG];
        second_source_register_o = word1_i[F_SRC_LSB +: W_REG];
        src_mode_o = word1_i[F_SMODE_LSB +: W_MODE];
      end
      default: begin
      end
    endcase
  end

endmodule

/* core/iwd_decode.sv */
// instruction word decode and execution cycle timing, top level
`timescale 1ns/1ns
module iwd_decode
  import iwd_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // fetch side
  input wire logic FETCH_VALID_I,
  input wire logic [W_WORD-1:0] FETCH_WORD_I,
  output logic FETCH_READY_O,
  // condition result from datapath, same clock
  input wire logic COND_TRUE_I,
  // decoded instruction
  output logic DEC_VALID_O,
  output iwd_cat_t CATEGORY_O,
  output logic [W_OPC-1:0] OPCODE_O,
  output logic [1:0] CYCLES_O,
  output logic NOP_SLOT_O,
  // operands
  output logic [W_REG-1:0] BASE_SOURCE_REGISTER_O,
  output logic [W_REG-1:0] SECOND_SOURCE_REGISTER_O,
  output logic [W_MODE-1:0] SRC_MODE_O,
  output logic [W_REG-1:0] DESTINATION_REGISTER_O,
  output logic [W_MODE-1:0] DST_MODE_O,
  output logic [W_FADDR-1:0] FILE_ADDR_O,
  output logic FILE_TO_WORKING_REG_ZERO_O,
  output logic [W_REG-1:0] BIT_POS_O,
  output logic BIT_INDIRECT_O,
  output logic [W_LIT-1:0] LITERAL_O,
  output logic [W_PADDR-1:0] PROG_ADDR_O,
  output logic [W_TMODE-1:0] TABLE_MODE_O,
  output logic DEST_SEPARATE_O
);

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SECOND, ST_HOLD} iwd_state_t;

  iwd_state_t state;
  logic [W_WORD-1:0] first_word;
  logic [1:0] hold_left;
  logic skip_next;
  logic skip_second;
  logic accept;
  logic [W_OPC-1:0] in_opc;
  iwd_cat_t dec_cat;
  logic [W_WORD-1:0] dec_w1;
  logic [W_WORD-1:0] dec_w2;
  logic dec_fire;
  logic flush;
  logic [1:0] next_cycles;

  logic [W_REG-1:0] f_base, f_src, f_dst, f_bit;
  logic [W_MODE-1:0] f_smode, f_dmode;
  logic [W_FADDR-1:0] f_faddr;
  logic f_fwreg, f_bind, f_dsep;
  logic [W_LIT-1:0] f_lit;
  logic [W_PADDR-1:0] f_paddr;
  logic [W_TMODE-1:0] f_tmode;

  assign accept = FETCH_VALID_I && FETCH_READY_O;
  // opcode taken from the top byte
  assign in_opc = FETCH_WORD_I[OPC_LSB +: W_OPC];
  // skipped words are swallowed, never decoded
  assign flush = accept && state == ST_RUN && (skip_next || skip_second);
  // second word completes the 48-bit encoding
  assign dec_fire = accept && !flush &&
                    (state == ST_SECOND || !iwd_two_word(in_opc));
  assign dec_w1 = (state == ST_SECOND) ? first_word : FETCH_WORD_I;
  assign dec_w2 = (state == ST_SECOND) ? FETCH_WORD_I : '0;
  assign dec_cat = iwd_classify(dec_w1[OPC_LSB +: W_OPC]);

  // execution cycles for the instruction being decoded
  always_comb begin
    next_cycles = CYC_ONE;
    unique case (dec_cat)
      // returns pay for the stack pop and refill
      CAT_RETURN, CAT_RETURN_FROM_INTERRUPT: next_cycles = CYC_THREE;
      CAT_BRANCH, CAT_CALL_IND, CAT_GOTO_IND, CAT_TABLE: next_cycles = CYC_TWO;
      CAT_CALL_ABS, CAT_GOTO_ABS, CAT_LIT_MOV_F, CAT_MOV_DW: next_cycles = CYC_TWO;
      CAT_COND_BRANCH: next_cycles = COND_TRUE_I ? CYC_TWO : CYC_ONE;
      default: next_cycles = CYC_ONE;
    endcase
  end

  iwd_fields u_fields (
    .cat_i(dec_cat),
    .word1_i(dec_w1),
    .word2_i(dec_w2),
    .base_source_register_o(f_base),
    .second_source_register_o(f_src),
    .src_mode_o(f_smode),
    .destination_register_o(f_dst),
    .dst_mode_o(f_dmode),
    .file_addr_o(f_faddr),
    .file_to_working_reg_zero_o(f_fwreg),
    .bit_pos_o(f_bit),
    .bit_indirect_o(f_bind),
    .literal_o(f_lit),
    .prog_addr_o(f_paddr),
    .table_mode_o(f_tmode),
    .dest_separate_o(f_dsep)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // word gathering and stall cycles; stall cycles stand in for no-operations
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      state <= ST_RUN;
      first_word <= '0;
      hold_left <= CYC_ZERO;
      FETCH_READY_O <= 1'b0;
    end else begin
      unique case (state)
        ST_RUN: begin
          FETCH_READY_O <= 1'b1;
          // only listed opcodes wait for a second word
          if (accept && !flush && iwd_two_word(in_opc)) begin
            first_word <= FETCH_WORD_I;
            state <= ST_SECOND;
          end else if (dec_fire && next_cycles != CYC_ONE) begin
            hold_left <= next_cycles - CYC_ONE;
            state <= ST_HOLD;
            FETCH_READY_O <= 1'b0;
          end
        end
        // the second fetch is itself the second cycle, so no hold
        ST_SECOND: begin
          if (accept) state <= ST_RUN;
        end
        ST_HOLD: begin
          hold_left <= hold_left - CYC_ONE;
          if (hold_left == CYC_ONE) begin
            state <= ST_RUN;
            FETCH_READY_O <= 1'b1;
          end
        end
        // unused state code falls back to fetching
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // skip one word, or two if it opens a two-word instruction
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      skip_next <= 1'b0;
      skip_second <= 1'b0;
    end else if (flush) begin
      skip_next <= 1'b0;
      skip_second <= skip_next && iwd_two_word(in_opc);
    end else if (dec_fire) begin
      skip_next <= dec_cat == CAT_SKIP && COND_TRUE_I;
    end
  end

  // no-operation slots: stall cycles and swallowed words
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      NOP_SLOT_O <= 1'b0;
    end else begin
      NOP_SLOT_O <= flush || state == ST_HOLD;
    end
  end

  // registered decode results
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      DEC_VALID_O <= 1'b0;
      CATEGORY_O <= CAT_NOP;
      OPCODE_O <= OP_NOP;
      CYCLES_O <= CYC_ZERO;
      BASE_SOURCE_REGISTER_O <= '0;
      SECOND_SOURCE_REGISTER_O <= '0;
      SRC_MODE_O <= '0;
      DESTINATION_REGISTER_O <= '0;
      DST_MODE_O <= '0;
      FILE_ADDR_O <= '0;
      FILE_TO_WORKING_REG_ZERO_O <= 1'b0;
      BIT_POS_O <= '0;
      BIT_INDIRECT_O <= 1'b0;
      LITERAL_O <= '0;
      PROG_ADDR_O <= '0;
      TABLE_MODE_O <= '0;
      DEST_SEPARATE_O <= 1'b0;
    end else begin
      DEC_VALID_O <= dec_fire;
      if (dec_fire) begin
        CATEGORY_O <= dec_cat;
        OPCODE_O <= dec_w1[OPC_LSB +: W_OPC];
        CYCLES_O <= next_cycles;
        BASE_SOURCE_REGISTER_O <= f_base;
        SECOND_SOURCE_REGISTER_O <= f_src;
        SRC_MODE_O <= f_smode;
        DESTINATION_REGISTER_O <= f_dst;
        DST_MODE_O <= f_dmode;
        FILE_ADDR_O <= f_faddr;
        FILE_TO_WORKING_REG_ZERO_O <= f_fwreg;
        BIT_POS_O <= f_bit;
        BIT_INDIRECT_O <= f_bind;
        LITERAL_O <= f_lit;
        PROG_ADDR_O <= f_paddr;
        TABLE_MODE_O <= f_tmode;
        DEST_SEPARATE_O <= f_dsep;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OPC_TOP: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    dec_fire |=> OPCODE_O == $past(dec_w1[OPC_LSB +: W_OPC]))
    else $error("opcode not taken from top byte");
  AST_TWO_WORD_WAIT: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (accept && !flush && state == ST_RUN && iwd_two_word(in_opc)) |=> !DEC_VALID_O)
    else $error("two-word instruction decoded from one word");
  AST_LONE_SECOND_NOP: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && state == ST_RUN && in_opc == OP_NOP) |=> CATEGORY_O == CAT_NOP)
    else $error("lone second word not a no-operation");
  AST_RETURN_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && (dec_cat == CAT_RETURN || dec_cat == CAT_RETURN_FROM_INTERRUPT))
      |=> !FETCH_READY_O [*2] ##1 FETCH_READY_O)
    else $error("return did not take three cycles");
  AST_BRANCH_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && dec_cat == CAT_COND_BRANCH && COND_TRUE_I)
      |=> !FETCH_READY_O ##1 FETCH_READY_O)
    else $error("taken branch did not take two cycles");
  AST_PLAIN_ONE: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && dec_cat == CAT_WORKING_REG_ZERO) |=> FETCH_READY_O && CYCLES_O == CYC_ONE)
    else $error("plain instruction stalled");
  AST_SKIP_TWO_WORD: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (flush && skip_next && iwd_two_word(in_opc)) |=> skip_second && !skip_next)
    else $error("skip over two-word instruction lost its second word");
  AST_TWO_WORD_CYC: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && state == ST_SECOND) |=> CYCLES_O == CYC_TWO && FETCH_READY_O)
    else $error("two-word instruction not two cycles");
  AST_LIT_DEST: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (DEC_VALID_O && CATEGORY_O == CAT_LIT_ARITH && !DEST_SEPARATE_O)
      |-> DESTINATION_REGISTER_O == BASE_SOURCE_REGISTER_O)
    else $error("literal result not returned to source");
  AST_FILE_RANGE: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (dec_fire && dec_cat == CAT_FILE)
      |=> FILE_ADDR_O == $past(dec_w1[F_FADDR_LSB +: W_FADDR])
        && DESTINATION_REGISTER_O == WORKING_REG_ZERO_ZERO)
    else $error("file address not taken in full");

endmodule

/* verif/iwd_fetch_model.sv */
// fetch side model: offers program words to the decoder one at a time
`timescale 1ns/1ns
module iwd_fetch_model
  import iwd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // handshake with the decoder
  input wire logic fetch_ready_i,
  input wire logic slow_i,
  output logic fetch_valid_o,
  output logic [W_WORD-1:0] fetch_word_o
);
  logic [W_WORD-1:0] words[$];
  logic gap;

  initial begin
    fetch_valid_o = 1'b0;
    fetch_word_o = '0;
    gap = 1'b0;
  end

  // queue access for the bench
  task automatic push(input logic [W_WORD-1:0] w);
    words.push_back(w);
  endtask
  function automatic int pending();
    return words.size();
  endfunction

  // word held until taken; slow mode idles one cycle after each take
  always @(posedge clk_i) begin
    gap = 1'b0;
    if (fetch_valid_o === 1'b1 && fetch_ready_i === 1'b1 && !rst_i) begin
      void'(words.pop_front());
      gap = slow_i;
    end
    #1;
    if (words.size() > 0 && !gap) begin
      fetch_valid_o = 1'b1;
      fetch_word_o = words[0];
    end else begin
      fetch_valid_o = 1'b0;
      fetch_word_o = ~fetch_word_o;  // released bus must not look stable
    end
  end
endmodule

/* verif/iwd_decode_bench.sv */
// self-checking bench for the instruction word decoder
`timescale 1ns/1ns
module iwd_decode_bench
  import iwd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cond = 1'b0;
  logic slow = 1'b0;
  logic fvalid, ready, dvalid, nop_slot, f2w, bit_ind, dsep;
  logic [W_WORD-1:0] fword;
  iwd_cat_t cat;
  logic [W_OPC-1:0] opc;
  logic [1:0] cyc;
  logic [W_REG-1:0] bsr, ssr, dr, bpos;
  logic [W_MODE-1:0] smode, dmode;
  logic [W_FADDR-1:0] faddr;
  logic [W_LIT-1:0] lit;
  logic [W_PADDR-1:0] paddr;
  logic [W_TMODE-1:0] tmode;
  int miscompares = 0;
  int check_count = 0;
  int dec_n, nop_n, stall_n;
  logic [7:0] ops [9] = '{8'hb8, 8'hb9, 8'ha0, 8'hb0, 8'hb1, 8'hb4, 8'hb7, 8'hc0, 8'h10};
  logic [1:0] exp_cyc [9] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};

  always #10 clk = ~clk;

  iwd_fetch_model fm (.clk_i(clk), .rst_i(rst), .fetch_ready_i(ready), .slow_i(slow),
    .fetch_valid_o(fvalid), .fetch_word_o(fword));

  iwd_decode uut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .FETCH_VALID_I(fvalid),
    .FETCH_WORD_I(fword), .FETCH_READY_O(ready), .COND_TRUE_I(cond), .DEC_VALID_O(dvalid),
    .CATEGORY_O(cat), .OPCODE_O(opc), .CYCLES_O(cyc), .NOP_SLOT_O(nop_slot),
    .BASE_SOURCE_REGISTER_O(bsr), .SECOND_SOURCE_REGISTER_O(ssr), .SRC_MODE_O(smode),
    .DESTINATION_REGISTER_O(dr), .DST_MODE_O(dmode), .FILE_ADDR_O(faddr),
    .FILE_TO_WORKING_REG_ZERO_O(f2w), .BIT_POS_O(bpos), .BIT_INDIRECT_O(bit_ind), .LITERAL_O(lit),
    .PROG_ADDR_O(paddr), .TABLE_MODE_O(tmode), .DEST_SEPARATE_O(dsep));

  // count decodes, no-operation slots and fetch stalls per scenario
  always @(posedge clk) begin
    if (dvalid === 1'b1) dec_n++;
    if (nop_slot === 1'b1) nop_n++;
    if (ready === 1'b0 && rst === 1'b0) stall_n++;
  end

  function automatic logic [11:0] cnt();
    return {dec_n[3:0], nop_n[3:0], stall_n[3:0]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // start a scenario with the condition level and fresh counters
  task automatic go(input logic c);
    @(posedge clk);
    #1;
    cond = c;
    dec_n = 0;
    nop_n = 0;
    stall_n = 0;
  endtask

  // bounded wait for the queue to drain, then let stalls run out
  task automatic settle();
    int i;
    for (i = 0; i < 300 && fm.pending() > 0; i++) @(posedge clk);
    if (fm.pending() > 0) begin
      miscompares++;
      summarize();
    end
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic one(input logic c, input logic [W_WORD-1:0] w);
    go(c);
    fm.push(w);
    settle();
  endtask

  task automatic t_reset();
    repeat (3) @(posedge clk);
    #1;
    chk({ready, dvalid, cat, cyc, lit, paddr}, '0);  // RESET
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(ready, 1'b1);  // RESET
    $display("reset test done");
  endtask

  task automatic t_forms();
    one(1'b0, {8'h10, 4'h3, 4'hc, 2'h1, 4'h9, 2'h2});
    chk({cat, opc, bsr, dr, dmode, ssr, smode}, {CAT_WORKING_REG_ZERO, 8'h10, 4'h3, 4'hc, 2'h1, 4'h9, 2'h2});
    one(1'b0, {8'h40, 2'h0, 1'b1, 13'h1fff});
    chk({cat, f2w, faddr}, {CAT_FILE, 1'b1, FADDR_MAX});
    one(1'b0, {8'h41, 2'h0, 1'b0, 13'h0000});
    chk({f2w, faddr}, {1'b0, 13'h0000});
    one(1'b0, {8'h60, 4'h7, 1'b1, 11'h0});
    chk({cat, bit_ind, bpos, bsr}, {CAT_BIT_W, 1'b1, 4'h0, 4'h7});
    one(1'b0, {8'h60, 4'h5, 1'b0, 1'b0, 10'h0});
    chk({bit_ind, bpos}, {1'b0, 4'h5});
    one(1'b0, {8'h71, 3'h5, 3'h0, 10'h155});
    chk({cat, bpos, faddr}, {CAT_BIT_F, 4'hd, 13'h0155});
    one(1'b0, {8'h80, 4'h2, 4'h2, 3'h0, 5'h1f});
    chk({cat, dsep, lit}, {CAT_LIT_ARITH, 1'b0, 16'h001f});
    one(1'b0, {8'h80, 4'h2, 4'h6, 3'h0, 5'h03});
    chk(dsep, 1'b1);
    one(1'b0, {8'hb5, 2'h2, 14'h0});
    chk({cat, tmode}, {CAT_TABLE, 2'h2});
    one(1'b0, {8'h90, 12'habc, 4'h4});
    chk({cat, lit}, {CAT_LIT_MOV_W, 16'h0abc});
    $display("operand form test done");
  endtask

  task automatic t_cycles();
    int k;
    for (k = 0; k < 9; k++) begin
      one(1'b0, {ops[k], 16'h0});
      chk({opc, cyc, cnt()}, {ops[k], exp_cyc[k], 4'h1, {2'h0, exp_cyc[k]} - 4'h1,
        {2'h0, exp_cyc[k]} - 4'h1});
    end
    go(1'b0);
    fm.push({8'hb8, 16'h0});
    fm.push({8'h10, 16'h0});
    settle();
    chk({opc, cyc, cnt()}, {8'h10, 2'h1, 12'h222});
    one(1'b1, {8'ha1, 16'h0});
    chk({cyc, cnt()}, {2'h2, 12'h111});
    one(1'b0, {8'ha1, 16'h0});
    chk({cyc, cnt()}, {2'h1, 12'h100});
    $display("cycle count test done");
  endtask

  task automatic t_two_word();
    slow = 1'b1;
    go(1'b0);
    fm.push({8'hb2, 16'h1234});
    fm.push({8'h00, 9'h0, 7'h55});
    settle();
    chk({cat, cyc, paddr, cnt()}, {CAT_CALL_ABS, 2'h2, 7'h55, 16'h1234, 12'h100});
    slow = 1'b0;
    go(1'b0);
    fm.push({8'h91, 3'h0, 13'h0abc});
    fm.push({8'h00, 16'hbeef});
    settle();
    chk({cat, cyc, faddr, lit, cnt()}, {CAT_LIT_MOV_F, 2'h2, 13'h0abc, 16'hbeef, 12'h100});
    one(1'b0, {8'h00, 16'hffff});
    chk({cat, cnt()}, {CAT_NOP, 12'h100});
    $display("two word test done");
  endtask

  task automatic t_skip();
    go(1'b1);
    fm.push({8'ha8, 16'h0});
    fm.push({8'hb3, 16'h0});
    fm.push({8'h00, 16'h0});
    fm.push({8'h10, 16'h0});
    settle();
    chk({opc, cnt()}, {8'h10, 12'h220});
    go(1'b1);
    fm.push({8'ha8, 16'h0});
    fm.push({8'h10, 16'h0});
    fm.push({8'h11, 16'h0});
    settle();
    chk({opc, cnt()}, {8'h11, 12'h210});
    go(1'b0);
    fm.push({8'ha8, 16'h0});
    fm.push({8'h10, 16'h0});
    settle();
    chk({opc, cnt()}, {8'h10, 12'h200});
    $display("skip test done");
  endtask

  initial begin
    t_reset();
    t_forms();
    t_cycles();
    t_two_word();
    t_skip();
    summarize();
  end
endmodule
